// file: hw/hub_pin_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - select low: mode 1, attach trio and orientation
// - select high: mode 2, orientation A/B attaches
// - unconnected select defaults to mode 1
// - serial interface slave or bridge master
// - speed indicator: float, 0 SuperSpeed, 1 USB2
// - suspend indicator follows USB 2.0 suspend
// - hub held in reset while reset low
// - straps latched at POR and reset rise
// - per-port D+/D- straps decide port disable
// - non-removable count from latched strap
// - charging port count from latched strap
// - device mode from latched mode strap
// - polarity high makes attach inputs active low
// - mode 1: orientation picks PHY B or A
// - mode 2: each attach powers its PHY
module hub_pin_ctrl
    import hub_pin_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     ext_reset_n,
    input  wire logic                     control_mode_select_in,
    input  wire logic [2:0]               attach_detect_in,
    input  wire logic                     plug_orientation_in,
    input  wire logic                     attach_orient_a_in,
    input  wire logic                     attach_orient_b_in,
    input  wire logic                     attach_polarity_in,
    input  wire logic [hub_pin_pkg::MODE_W-1:0] device_mode_strap,
    input  wire logic [hub_pin_pkg::PORTS-1:0]  port_off_dplus_strap,
    input  wire logic [hub_pin_pkg::PORTS-1:0]  port_off_dminus_strap,
    input  wire logic [hub_pin_pkg::CNT_W-1:0]  fixed_port_count_strap,
    input  wire logic [hub_pin_pkg::CNT_W-1:0]  charging_port_count_strap,
    input  wire logic                     upstream_connected,
    input  wire logic                     upstream_superspeed,
    input  wire logic                     usb2_suspended,
    output logic                          hub_in_reset,
    output logic                          phy_a_enable,
    output logic                          phy_b_enable,
    output logic [1:0]                    speed_ind,
    output logic                          speed_ind_oe,
    output logic                          suspend_indicator_out,
    output logic                          mgmt_master_mode,
    output logic [hub_pin_pkg::PORTS-1:0] port_disabled,
    output logic [hub_pin_pkg::CNT_W-1:0] fixed_port_count,
    output logic [hub_pin_pkg::CNT_W-1:0] charging_port_count
);
    import hub_pin_pkg::*;

    hub_state_t        state_r;
    hub_state_t        state_nxt;
    logic [2:0]        ctrl_r;
    logic              ext_rst_prev_r;
    logic              phy_a_nxt;
    logic              phy_b_nxt;
    logic [31:0]       rdata_nxt;

    strap_if s ();

    strap_latch u_straps (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (s)
    );

    // bus decode
    wire setup_ph   = psel && !penable;
    wire wr_access  = psel && penable && pwrite && pready;
    wire hit_ctrl   = paddr == ADDR_CTRL;
    wire hit_status = paddr == ADDR_STATUS;
    wire hit_straps = paddr == ADDR_STRAPS;
    wire hit_ports  = paddr == ADDR_PORTS;
    wire hit_any    = hit_ctrl || hit_status || hit_straps || hit_ports;
    wire ctrl_wr    = wr_access && hit_ctrl;
    wire relatch_rq = ctrl_wr && pwdata[CTRL_RELAT];

    // reset mode and latch timing
    wire hold_reset = !ext_reset_n || ctrl_r[CTRL_HOLD];
    wire ext_rise   = ext_reset_n && !ext_rst_prev_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: if (!hold_reset) state_nxt = ST_LATCH;
            ST_LATCH: state_nxt = hold_reset ? ST_RESET : ST_RUN;
            ST_RUN:
            begin
                if (hold_reset)
                    state_nxt = ST_RESET;
                else if (relatch_rq)
                    state_nxt = ST_LATCH;
            end
            default: state_nxt = ST_RESET;
        endcase
    end

    // first clock after POR sits in ST_LATCH; ext reset rise passes it too
    assign s.capture   = (state_r == ST_LATCH) && !hold_reset;
    assign s.mode_raw  = device_mode_strap;
    assign s.dp_raw    = port_off_dplus_strap;
    assign s.dm_raw    = port_off_dminus_strap;
    assign s.fixed_raw = fixed_port_count_strap;
    assign s.chg_raw   = charging_port_count_strap;

    // attach decode, polarity applied to every attach input
    wire       pol        = attach_polarity_in;
    wire [2:0] attach_eff = attach_detect_in ^ {3{pol}};
    wire       orient_eff = plug_orientation_in ^ pol;
    wire       att_a_eff  = attach_orient_a_in ^ pol;
    wire       att_b_eff  = attach_orient_b_in ^ pol;
    wire       any_attach = |attach_eff;
    wire       mode2      = control_mode_select_in;
    wire       run        = (state_r == ST_RUN) && !hold_reset;
    // phys follow the next state, so a relatch never leaves them on in reset
    wire       phy_ok     = (state_nxt == ST_RUN) && !ctrl_r[CTRL_PHYOFF];

    always_comb
    begin
        if (!mode2)
        begin
            phy_b_nxt = any_attach && orient_eff;
            phy_a_nxt = any_attach && !orient_eff;
        end
        else
        begin
            phy_a_nxt = att_a_eff;
            phy_b_nxt = att_b_eff;
        end
    end

    wire [1:0] speed_code = upstream_superspeed ? SPEED_SS : SPEED_HS;

    // read mux
    wire [31:0] status_word = {22'h0, ext_reset_n, usb2_suspended, state_r,
                               mode2, pol, hub_in_reset, phy_b_enable, phy_a_enable};
    wire [31:0] straps_word = {20'h0, mgmt_master_mode, charging_port_count,
                               fixed_port_count, s.mode_q, s.dm_q[0], s.dp_q[0]};
    wire [31:0] ports_word  = {8'h0, 2'h0, s.dm_q, 2'h0, s.dp_q,
                               2'h0, port_disabled};

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (hit_ctrl)
            rdata_nxt = {29'h0, ctrl_r[CTRL_PHYOFF], 1'b0, ctrl_r[CTRL_HOLD]};
        else if (hit_status)
            rdata_nxt = status_word;
        else if (hit_straps)
            rdata_nxt = straps_word;
        else if (hit_ports)
            rdata_nxt = ports_word;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !hit_any;
            prdata  <= (setup_ph && !pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= CTRL_RST;
        else if (ctrl_wr)
            ctrl_r <= {pwdata[CTRL_PHYOFF], 1'b0, pwdata[CTRL_HOLD]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r        <= ST_LATCH;
            ext_rst_prev_r <= 1'b1;
        end
        else
        begin
            state_r        <= state_nxt;
            ext_rst_prev_r <= ext_reset_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hub_in_reset          <= 1'b1;
            phy_a_enable          <= 1'b0;
            phy_b_enable          <= 1'b0;
            speed_ind             <= SPEED_SS;
            speed_ind_oe          <= 1'b0;
            suspend_indicator_out <= 1'b0;
        end
        else
        begin
            hub_in_reset          <= state_nxt != ST_RUN;
            phy_a_enable          <= phy_ok && phy_a_nxt;
            phy_b_enable          <= phy_ok && phy_b_nxt;
            speed_ind             <= speed_code;
            speed_ind_oe          <= run && upstream_connected;
            suspend_indicator_out <= run && usb2_suspended;
        end
    end

    // configuration outputs from latched straps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mgmt_master_mode    <= 1'b0;
            port_disabled       <= '0;
            fixed_port_count    <= '0;
            charging_port_count <= '0;
        end
        else
        begin
            mgmt_master_mode    <= s.mode_q == MODE_BRIDGE;
            port_disabled       <= s.dp_q & s.dm_q;
            fixed_port_count    <= s.fixed_q;
            charging_port_count <= s.chg_q;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_hold: assert property (!ext_reset_n |=> hub_in_reset)
        else $error("hub left reset while reset input low");
    a_relatch_edge: assert property (ext_rise && !ctrl_r[CTRL_HOLD]
        |-> ##1 s.capture)
        else $error("no strap capture after reset rise");
    a_mode1_phy: assert property (run && !relatch_rq && !ctrl_r[CTRL_PHYOFF] && !mode2
        && any_attach |=> phy_b_enable == $past(orient_eff))
        else $error("mode 1 phy select wrong");
    a_mode2_phy: assert property (run && !relatch_rq && !ctrl_r[CTRL_PHYOFF] && mode2
        |=> phy_a_enable == $past(att_a_eff) && phy_b_enable == $past(att_b_eff))
        else $error("mode 2 phy enables wrong");
    a_mode1_ignore: assert property (!mode2 && !any_attach |=> !phy_a_enable
        && !phy_b_enable)
        else $error("phy on without mode 1 attach");
    a_speed_float: assert property (!upstream_connected |=> !speed_ind_oe)
        else $error("speed indicator driven while unconnected");
    a_speed_value: assert property (run && upstream_connected
        |=> speed_ind_oe && speed_ind == ($past(upstream_superspeed) ? 2'h0 : 2'h1))
        else $error("speed indicator value wrong");
    a_suspend_out: assert property (run |=> suspend_indicator_out == $past(usb2_suspended))
        else $error("suspend indicator mismatch");
    a_port_off: assert property (##1 port_disabled == ($past(s.dp_q) & $past(s.dm_q)))
        else $error("port disable combine wrong");
    a_master_mode: assert property (##1 mgmt_master_mode == ($past(s.mode_q) == MODE_BRIDGE))
        else $error("management role wrong");
    a_no_phy_reset: assert property (hub_in_reset |-> !phy_a_enable && !phy_b_enable)
        else $error("phy enabled in reset mode");

    c_mode1_b: cover property (!mode2 && phy_b_enable);
    c_mode2_a: cover property (mode2 && phy_a_enable);
    c_relatch: cover property (ext_rise ##1 s.capture);
    c_suspend: cover property (suspend_indicator_out);
endmodule : hub_pin_ctrl

// file: inc/hub_pin_pkg.sv
package hub_pin_pkg;
    localparam int          PORTS       = 6;
    localparam int          CNT_W       = 3;
    localparam int          MODE_W      = 3;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_STRAPS = 12'h008;
    localparam logic [11:0] ADDR_PORTS  = 12'h00C;
    localparam int          CTRL_HOLD   = 0;
    localparam int          CTRL_RELAT  = 1;
    localparam int          CTRL_PHYOFF = 2;
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [MODE_W-1:0] MODE_BRIDGE = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SLAVE  = 3'h1;
    localparam logic [1:0]  SPEED_SS    = 2'h0;
    localparam logic [1:0]  SPEED_HS    = 2'h1;
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_LATCH = 3'b010,
        ST_RUN   = 3'b100
    } hub_state_t;
endpackage : hub_pin_pkg

// file: inc/strap_if.sv
`timescale 1ns/1ps
interface strap_if;
    import hub_pin_pkg::*;
    logic                    capture;
    logic [MODE_W-1:0]       mode_raw;
    logic [PORTS-1:0]        dp_raw;
    logic [PORTS-1:0]        dm_raw;
    logic [CNT_W-1:0]        fixed_raw;
    logic [CNT_W-1:0]        chg_raw;
    logic [MODE_W-1:0]       mode_q;
    logic [PORTS-1:0]        dp_q;
    logic [PORTS-1:0]        dm_q;
    logic [CNT_W-1:0]        fixed_q;
    logic [CNT_W-1:0]        chg_q;
    modport holder (input capture, mode_raw, dp_raw, dm_raw, fixed_raw, chg_raw,
                    output mode_q, dp_q, dm_q, fixed_q, chg_q);
    modport user (output capture, mode_raw, dp_raw, dm_raw, fixed_raw, chg_raw,
                  input mode_q, dp_q, dm_q, fixed_q, chg_q);
endinterface : strap_if

// file: hw/strap_latch.sv
`timescale 1ns/1ps
module strap_latch
    import hub_pin_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    strap_if.holder   s
);
    // values only move on capture or reset, shared pins free afterwards
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s.mode_q  <= MODE_SLAVE;
            s.dp_q    <= '0;
            s.dm_q    <= '0;
            s.fixed_q <= '0;
            s.chg_q   <= '0;
        end
        else if (s.capture)
        begin
            s.mode_q  <= s.mode_raw;
            s.dp_q    <= s.dp_raw;
            s.dm_q    <= s.dm_raw;
            s.fixed_q <= s.fixed_raw;
            s.chg_q   <= s.chg_raw;
        end
    end

    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !s.capture |=> $stable(s.dp_q) && $stable(s.chg_q))
        else $error("strap values moved without capture");
endmodule : strap_latch

// file: tb/hub_far_side.sv
`timescale 1ns/1ps
module hub_far_side (
    input  wire logic       mode_drive,
    input  wire logic       mode_val,
    input  wire logic       pol,
    input  wire logic       reset_hold,
    input  wire logic [2:0] att,
    input  wire logic       ori,
    input  wire logic       att_a,
    input  wire logic       att_b,
    output logic            control_mode_select_in,
    output logic            attach_polarity_in,
    output logic            ext_reset_n,
    output logic [2:0]      attach_detect_in,
    output logic            plug_orientation_in,
    output logic            attach_orient_a_in,
    output logic            attach_orient_b_in
);
    // floating select pin falls to its pull-down level
    assign control_mode_select_in = mode_drive ? mode_val : 1'b0;
    assign attach_polarity_in     = pol;
    // logical attach levels, inverted on the pins when polarity is high
    assign attach_detect_in       = att ^ {3{pol}};
    assign plug_orientation_in    = ori ^ pol;
    assign attach_orient_a_in     = att_a ^ pol;
    assign attach_orient_b_in     = att_b ^ pol;
    assign ext_reset_n            = !reset_hold;
endmodule : hub_far_side

// file: tb/hub_pin_control_and_strap_latch_test.sv
`timescale 1ns/1ps
module hub_pin_control_and_strap_latch_test;
    import hub_pin_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, hub_in_reset, phy_a_enable, phy_b_enable;
    logic mode_drive = 1, mode_val = 0, pol = 0, reset_hold = 0, ori = 0, att_a = 0, att_b = 0;
    logic [2:0] att = 3'h0, mode_s = MODE_BRIDGE, fix_s = 3'h5, chg_s = 3'h2;
    logic [5:0] dp_s = 6'h3C, dm_s = 6'h0F;
    logic up_c = 0, up_ss = 0, susp = 0;
    logic cms, polp, ext_reset_n, ori_p, att_ap, att_bp, speed_ind_oe, suspend_indicator_out;
    logic mgmt_master_mode;
    logic [2:0] att_p, fixed_port_count, charging_port_count;
    logic [1:0] speed_ind;
    logic [5:0] port_disabled;
    logic [9:0] rows [9];
    int num_errors = 0, num_checks = 0, cycles = 0;
    initial forever #12.5 pclk = ~pclk;
    hub_far_side far (.mode_drive(mode_drive), .mode_val(mode_val), .pol(pol),
        .reset_hold(reset_hold), .att(att), .ori(ori), .att_a(att_a), .att_b(att_b),
        .control_mode_select_in(cms), .attach_polarity_in(polp), .ext_reset_n(ext_reset_n),
        .attach_detect_in(att_p), .plug_orientation_in(ori_p),
        .attach_orient_a_in(att_ap), .attach_orient_b_in(att_bp));
    hub_pin_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n(ext_reset_n), .control_mode_select_in(cms),
        .attach_detect_in(att_p), .plug_orientation_in(ori_p), .attach_orient_a_in(att_ap),
        .attach_orient_b_in(att_bp), .attach_polarity_in(polp), .device_mode_strap(mode_s),
        .port_off_dplus_strap(dp_s), .port_off_dminus_strap(dm_s),
        .fixed_port_count_strap(fix_s), .charging_port_count_strap(chg_s),
        .upstream_connected(up_c), .upstream_superspeed(up_ss), .usb2_suspended(susp),
        .hub_in_reset(hub_in_reset), .phy_a_enable(phy_a_enable),
        .phy_b_enable(phy_b_enable), .speed_ind(speed_ind), .speed_ind_oe(speed_ind_oe),
        .suspend_indicator_out(suspend_indicator_out), .mgmt_master_mode(mgmt_master_mode),
        .port_disabled(port_disabled), .fixed_port_count(fixed_port_count),
        .charging_port_count(charging_port_count));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // request stands until pready is seen high at a rising edge
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task settle;
        repeat (4) @(posedge pclk);
        #1;
    endtask : settle
    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            conclude();
        end
    end
    initial
    begin
        // mode, pol, attach trio, orient, attach a, attach b, expected phy a, phy b
        rows = '{10'b0_0_001_1_00_01, 10'b0_0_100_0_00_10, 10'b0_1_010_0_00_10,
                 10'b0_0_000_1_00_00, 10'b0_0_000_0_11_00, 10'b1_0_000_0_10_10,
                 10'b1_1_000_0_01_01, 10'b1_0_111_1_00_00, 10'b1_0_000_0_11_11};
        repeat (6) @(posedge pclk);
        presetn <= 1;
        settle();
        check(hub_in_reset, 0);
        check(port_disabled, 6'h0C);
        check({fixed_port_count, charging_port_count}, 6'h2A);
        check(mgmt_master_mode, 1);
        foreach (rows[i])
        begin
            @(posedge pclk);
            {mode_val, pol, att, ori, att_a, att_b} <= rows[i][9:2];
            settle();
            check({phy_a_enable, phy_b_enable}, rows[i][1:0]);
        end
        @(posedge pclk);
        {mode_drive, pol, att, ori, att_a, att_b} <= 8'b0_0_001_0_01;
        settle();
        check({phy_a_enable, phy_b_enable}, 2'b10);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge pclk);
            up_c <= k > 0; up_ss <= k == 1; susp <= k[0];
            settle();
            check(speed_ind_oe, k > 0);
            if (k > 0)
                check(speed_ind, k == 1 ? SPEED_SS : SPEED_HS);
            check(suspend_indicator_out, k[0]);
        end
        @(posedge pclk);
        mode_s <= MODE_SLAVE; dp_s <= 6'h21; dm_s <= 6'h3F; fix_s <= 3'h1; chg_s <= 3'h6;
        settle();
        check(port_disabled, 6'h0C);
        check(mgmt_master_mode, 1);
        @(posedge pclk);
        reset_hold <= 1;
        settle();
        check(hub_in_reset, 1);
        check({phy_a_enable, phy_b_enable}, 2'b00);
        @(posedge pclk);
        reset_hold <= 0;
        settle();
        check(hub_in_reset, 0);
        check(port_disabled, 6'h21);
        check({fixed_port_count, charging_port_count}, 6'h0E);
        check(mgmt_master_mode, 0);
        apb(0, ADDR_STRAPS, 0);
        check(rd[11:2], {1'b0, 3'h6, 3'h1, MODE_SLAVE});
        check(err, 0);
        apb(1, ADDR_CTRL, 32'h0000_0001);
        settle();
        check(hub_in_reset, 1);
        apb(1, ADDR_CTRL, 32'h0000_0004);
        settle();
        check({hub_in_reset, phy_a_enable}, 2'b00);
        apb(0, ADDR_CTRL, 0);
        check(rd, 32'h0000_0004);
        apb(1, ADDR_CTRL, 32'h0000_0000);
        apb(0, 12'h010, 0);
        check(err, 1);
        check(rd, 32'h0000_0000);
        // software relatch picks up straps changed while running
        @(posedge pclk);
        mode_s <= MODE_BRIDGE;
        dp_s <= 6'h12;
        apb(1, ADDR_CTRL, 32'h0000_0002);
        settle();
        check(port_disabled, 6'h12);
        check(mgmt_master_mode, 1);
        check({hub_in_reset, phy_a_enable}, 2'b01);
        apb(0, ADDR_CTRL, 0);
        check(rd, 32'h0000_0000);
        // second power-on reset in mid-run
        @(posedge pclk);
        presetn <= 0;
        dp_s <= 6'h3F;
        chg_s <= 3'h4;
        @(posedge pclk);
        #1;
        check(hub_in_reset, 1);
        check(port_disabled, 6'h00);
        @(posedge pclk);
        presetn <= 1;
        settle();
        check(hub_in_reset, 0);
        check(port_disabled, 6'h3F);
        check(charging_port_count, 3'h4);
        conclude();
    end
endmodule : hub_pin_control_and_strap_latch_test
